// [vpcs_path_connect_source.sv]
// VC-12 connection matrix with 1+1 protection and the VC-12 trail source.
// Assumes every pin input outside the register port is asynchronous to clk_sys and that each link
// clock is slower than a quarter of clk_sys, so its edges are seen.
`timescale 1ns/1ns

// How it works
// - Software connects or removes an input point to each output point.
// - Each connection keeps a type and a direction bit.
// - Several outputs may select one input, forming a broadcast.
// - Reconfiguring leaves the selected input alone unless a switch is due.
// - Unconnected outputs carry all-zero unequipped frames on local timing.
// - An output may be made a 1+1 protected group.
// - Protected sink picks working or protection from fail, degrade, commands.
// - Lockout, forced, manual and clear commands; to-working only non-revertive.
// - Revertive return waits the programmed wait-to-restore in 100 ms steps.
// - Working failure must persist the hold-off delay before switching.
// - Fail is server fail for inherent, trail fail and degrade otherwise.
// - Trace byte carries the sent trace identifier, sixteen bytes cycling.
// - Status bit 3 is one when the remote error count is one or two.
// - Status bit 8 follows the remote defect request every frame.
// - Status bits 1 and 2 are even parity over the previous frame.
// - Extended status bits 5 to 7 are sent as 000.
// - Extended status bit 8 is sent as zero.
// - Client bytes and signal label pass through unchanged.
module vpcs_path_connect_source #(
   parameter int unsigned STEP_CYC = `VPCS_STEP_CYC
) (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      reset_n,
   // Connection points
   input  wire vpcs_pkg::vpcs_cp_type [3:0]  cp_in,
   output      vpcs_pkg::vpcs_cpo_type [3:0] cp_out,
   // Local timing for unequipped frames
   input  wire logic                      ti_ck,
   input  wire logic                      ti_fs,
   // Trail source stream
   input  wire vpcs_pkg::vpcs_ai_type     ai_in,
   input  wire logic [1:0]                remote_error_request,
   input  wire logic                      remote_defect_request,
   output      vpcs_pkg::vpcs_ai_type     ci_out,
   // Register port
   input  wire logic [7:0]                reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output      logic [31:0]               reg_rdata
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      vpcs_pkg::vpcs_cp_type [3:0]  s1_cp;
      vpcs_pkg::vpcs_cp_type [3:0]  s2_cp;
      logic [1:0]                   s1_ti;
      logic [1:0]                   s2_ti;
      vpcs_pkg::vpcs_ai_type        s1_ai;
      vpcs_pkg::vpcs_ai_type        s2_ai;
      logic                         ai_ck_prev;
      logic [2:0]                   s1_rr;
      logic [2:0]                   s2_rr;
      logic [24:0]                  tick_cnt;
      logic                         tick;
      vpcs_pkg::vpcs_grp_type [3:0] grp;
      logic [127:0]                 trace;
      logic [7:0]                   pos;
      logic [3:0]                   tr_idx;
      logic [7:0]                   bip;
      vpcs_pkg::vpcs_ai_type        ci;
      logic [31:0]                  rdata;
   } vpcs_state_type;

   vpcs_state_type st;
   vpcs_state_type next_st;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Fail and degrade of one input for the group's monitoring kind
   // fail source select
   function automatic logic [1:0] fail_of(
      input vpcs_pkg::vpcs_cp_type cp,
      input vpcs_pkg::vpcs_kind_type kind
   );
      logic [1:0] r;
      r = 2'h0;
      if (kind == vpcs_pkg::vpcs_inherent) begin
         r = {cp.ssf, 1'b0};
      end else begin
         r = {cp.tsf, cp.tsd};
      end
      return r;
   endfunction

   // Even parity over bit pairs, MSB is bit 1
   function automatic logic [1:0] bip_of(input logic [7:0] x);
      return {x[7] ^ x[5] ^ x[3] ^ x[1], x[6] ^ x[4] ^ x[2] ^ x[0]};
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [1:0]  fw;
      logic [1:0]  fp;
      logic        held;
      logic        want;
      logic        wtr_go;
      logic [1:0]  w;
      logic [1:0]  p;
      logic [1:0]  g_sel;
      logic [7:0]  b;
      logic [7:0]  pos_now;
      vpcs_pkg::vpcs_cmd_type c;
      fw      = 2'h0;
      fp      = 2'h0;
      held    = 1'b0;
      want    = 1'b0;
      wtr_go  = 1'b0;
      w       = 2'h0;
      p       = 2'h0;
      g_sel   = reg_addr[5:4];
      b       = 8'h00;
      pos_now = 8'h00;
      c       = vpcs_pkg::vpcs_cmd_none;
      next_st = st;

      // Pin synchronisers, first stage feeds only the second
      next_st.s1_cp = cp_in;
      next_st.s2_cp = st.s1_cp;
      next_st.s1_ti = {ti_ck, ti_fs};
      next_st.s2_ti = st.s1_ti;
      next_st.s1_ai = ai_in;
      next_st.s2_ai = st.s1_ai;
      next_st.s1_rr = {remote_error_request, remote_defect_request};
      next_st.s2_rr = st.s1_rr;

      // 100 ms step tick shared by hold-off and wait-to-restore
      next_st.tick     = (st.tick_cnt == 25'(STEP_CYC - 1));
      next_st.tick_cnt = next_st.tick ? 25'h000_0000 : st.tick_cnt + 25'h000_0001;

      // Per output point selection and drive
      for (int g = 0; g < `VPCS_POINTS; g++) begin
         w  = st.grp[g].work_idx;
         p  = st.grp[g].prot_idx;
         fw = fail_of(st.s2_cp[w], st.grp[g].kind);
         fp = fail_of(st.s2_cp[p], st.grp[g].kind);

         if (fw == 2'h0) begin
            next_st.grp[g].ho_cnt = 7'h00;
         end else if (st.tick && st.grp[g].ho_cnt < st.grp[g].holdoff) begin
            next_st.grp[g].ho_cnt = st.grp[g].ho_cnt + 7'h01;
         end
         held = (st.grp[g].ho_cnt >= st.grp[g].holdoff);

         // selector priority: commands, fail, degrade, manual, restore
         want   = st.grp[g].use_prot;
         wtr_go = 1'b0;
         if (st.grp[g].cmd == vpcs_pkg::vpcs_cmd_lockout) begin
            want = 1'b0;
         end else if (st.grp[g].cmd == vpcs_pkg::vpcs_cmd_force_prot) begin
            want = 1'b1;
         end else if (st.grp[g].cmd == vpcs_pkg::vpcs_cmd_force_work) begin
            want = 1'b0;
         end else if (fw[1] && held && !fp[1]) begin
            want = 1'b1;
         end else if (fp[1]) begin
            want = 1'b0;
         end else if (fw[0] && held && !fp[0]) begin
            want = 1'b1;
         end else if (st.grp[g].cmd == vpcs_pkg::vpcs_cmd_manual_prot) begin
            want = 1'b1;
         end else if (st.grp[g].cmd == vpcs_pkg::vpcs_cmd_manual_work) begin
            want = 1'b0;
         end else if (st.grp[g].revert && st.grp[g].use_prot) begin
            wtr_go = 1'b1;
            if (st.grp[g].wtr_cnt >= st.grp[g].wtr) begin
               want = 1'b0;
            end
         end
         if (!st.grp[g].prot_on) begin
            want = 1'b0;
         end
         next_st.grp[g].use_prot = want;
         if (!wtr_go) begin
            next_st.grp[g].wtr_cnt = 13'h0000;
         end else if (st.tick && st.grp[g].wtr_cnt < st.grp[g].wtr) begin
            next_st.grp[g].wtr_cnt = st.grp[g].wtr_cnt + 13'h0001;
         end

         if (!st.grp[g].conn) begin
            // unequipped frame, valid start, no server fail
            next_st.grp[g].out.d   = 8'h00;
            next_st.grp[g].out.ck  = st.s2_ti[1];
            next_st.grp[g].out.fs  = st.s2_ti[0];
            next_st.grp[g].out.ssf = 1'b0;
         end else begin
            // any number of outputs may share one input
            if (st.grp[g].use_prot) begin
               next_st.grp[g].out.d   = st.s2_cp[p].d;
               next_st.grp[g].out.ck  = st.s2_cp[p].ck;
               next_st.grp[g].out.fs  = st.s2_cp[p].fs;
               next_st.grp[g].out.ssf = st.s2_cp[p].ssf;
            end else begin
               next_st.grp[g].out.d   = st.s2_cp[w].d;
               next_st.grp[g].out.ck  = st.s2_cp[w].ck;
               next_st.grp[g].out.fs  = st.s2_cp[w].fs;
               next_st.grp[g].out.ssf = st.s2_cp[w].ssf;
            end
         end
      end

      // ****************************************************************
      // Register writes
      // ****************************************************************
      if (reg_wr) begin
         if (reg_addr[7:6] == 2'h0 && reg_addr[3:2] == `VPCS_REG_CONN) begin
            // connection setup, selection kept as is
            next_st.grp[g_sel].conn     = reg_wdata[`VPCS_BIT_CONN];
            next_st.grp[g_sel].prot_on  = reg_wdata[`VPCS_BIT_PROT];
            next_st.grp[g_sel].revert   = reg_wdata[`VPCS_BIT_REVERT];
            next_st.grp[g_sel].bidir    = reg_wdata[`VPCS_BIT_BIDIR];
            next_st.grp[g_sel].kind     = vpcs_pkg::vpcs_kind_type'(reg_wdata[5:4]);
            next_st.grp[g_sel].work_idx = reg_wdata[9:8];
            next_st.grp[g_sel].prot_idx = reg_wdata[11:10];
         end else if (reg_addr[7:6] == 2'h0 && reg_addr[3:2] == `VPCS_REG_HOLD) begin
            next_st.grp[g_sel].holdoff = reg_wdata[6:0];
         end else if (reg_addr[7:6] == 2'h0 && reg_addr[3:2] == `VPCS_REG_WTR) begin
            next_st.grp[g_sel].wtr = reg_wdata[12:0];
         end else if (reg_addr[7:6] == 2'h0) begin
            c = vpcs_pkg::vpcs_cmd_type'(reg_wdata[2:0]);
            if (c == vpcs_pkg::vpcs_cmd_clear) begin
               next_st.grp[g_sel].cmd = vpcs_pkg::vpcs_cmd_none;
            end else if (reg_wdata[2:0] == 3'h7 || c == vpcs_pkg::vpcs_cmd_none) begin
               next_st.grp[g_sel].cmd = st.grp[g_sel].cmd;
            end else if (st.grp[g_sel].revert && (c == vpcs_pkg::vpcs_cmd_force_work ||
                         c == vpcs_pkg::vpcs_cmd_manual_work)) begin
               next_st.grp[g_sel].cmd = st.grp[g_sel].cmd;
            end else begin
               next_st.grp[g_sel].cmd = c;
            end
         end else if (reg_addr[7:6] == `VPCS_TRACE_BASE) begin
            // trace identifier words, word 0 holds bytes 0 to 3
            next_st.trace[{~reg_addr[3:2], 5'h00} +: 32] = reg_wdata;
         end
      end

      // ****************************************************************
      // Register reads, data stand the next cycle only
      // ****************************************************************
      next_st.rdata = 32'h0000_0000;
      if (reg_rd) begin
         if (reg_addr[7:6] == 2'h0 && reg_addr[3:2] == `VPCS_REG_CONN) begin
            next_st.rdata = {20'h0_0000, st.grp[g_sel].prot_idx, st.grp[g_sel].work_idx,
                             2'h0, st.grp[g_sel].kind, st.grp[g_sel].bidir,
                             st.grp[g_sel].revert, st.grp[g_sel].prot_on,
                             st.grp[g_sel].conn};
         end else if (reg_addr[7:6] == 2'h0 && reg_addr[3:2] == `VPCS_REG_HOLD) begin
            next_st.rdata = {25'h000_0000, st.grp[g_sel].holdoff};
         end else if (reg_addr[7:6] == 2'h0 && reg_addr[3:2] == `VPCS_REG_WTR) begin
            next_st.rdata = {19'h0_0000, st.grp[g_sel].wtr};
         end else if (reg_addr[7:6] == 2'h0) begin
            // Command in force and current selection
            next_st.rdata = {28'h000_0000, st.grp[g_sel].use_prot, st.grp[g_sel].cmd};
         end else if (reg_addr[7:6] == `VPCS_TRACE_BASE) begin
            next_st.rdata = st.trace[{~reg_addr[3:2], 5'h00} +: 32];
         end
      end

      // ****************************************************************
      // Trail source, one byte per rising edge of the stream clock
      // ****************************************************************
      next_st.ai_ck_prev = st.s2_ai.ck;
      next_st.ci.ck      = st.s2_ai.ck;
      // octet taken on its clock edge, frame start resets position
      if (st.s2_ai.ck && !st.ai_ck_prev) begin
         b = st.s2_ai.d;
         if (st.s2_ai.fs || st.pos == `VPCS_FRAME_LEN - 8'h01) begin
            pos_now = `VPCS_POS_STATUS;
         end else begin
            pos_now = st.pos + 8'h01;
         end
         if (pos_now == `VPCS_POS_STATUS) begin
            // parity of the whole previous frame
            b[7:6] = bip_of(st.bip);
            // remote error, one or two violations send one
            b[5] = |st.s2_rr[2:1];
            // remote defect, refreshed every 500 us frame
            b[0] = st.s2_rr[0];
            // bits 4 to 7 of the status byte pass through
            next_st.bip = b;
         end else begin
            if (pos_now == `VPCS_POS_TRACE) begin
               b = st.trace[{~st.tr_idx, 3'h0} +: 8];
               next_st.tr_idx = st.tr_idx + 4'h1;
            end else if (pos_now == `VPCS_POS_EXT) begin
               // extended status low nibble sent as zero
               b[3:0] = 4'h0;
            end
            next_st.bip = st.bip ^ b;
         end
         next_st.pos  = pos_now;
         next_st.ci.d = b;
         next_st.ci.fs = (pos_now == `VPCS_POS_STATUS);
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         for (int g = 0; g < `VPCS_POINTS; g++) begin
            st.grp[g].holdoff <= `VPCS_HOLD_RESET;
            st.grp[g].wtr     <= `VPCS_WTR_RESET;
         end
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state
   always_comb begin
      for (int g = 0; g < `VPCS_POINTS; g++) begin
         cp_out[g] = st.grp[g].out;
      end
   end

   assign ci_out    = st.ci;
   assign reg_rdata = st.rdata;

endmodule

// [vpcs_defs.svh]
// Constants of the VC-12 connection matrix and trail source:
// register offsets, field positions, reset values and timing counts.
// Assumes inclusion by both the package and the design module.
`ifndef VPCS_DEFS_SVH
`define VPCS_DEFS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define VPCS_POINTS      4
`define VPCS_FRAME_LEN   8'h8C
`define VPCS_POS_STATUS  8'h00
`define VPCS_POS_TRACE   8'h23
`define VPCS_POS_EXT     8'h69

// ****************************************************************
// Timing
// ****************************************************************
`define VPCS_CLK_MHZ     250
`define VPCS_STEP_MS     100
`define VPCS_STEP_CYC    (`VPCS_STEP_MS * 1000 * `VPCS_CLK_MHZ)

// ****************************************************************
// Register map, group base is index times 16
// ****************************************************************
`define VPCS_REG_CONN    2'h0
`define VPCS_REG_HOLD    2'h1
`define VPCS_REG_WTR     2'h2
`define VPCS_REG_CMD     2'h3
`define VPCS_TRACE_BASE  2'h1
`define VPCS_BIT_CONN    0
`define VPCS_BIT_PROT    1
`define VPCS_BIT_REVERT  2
`define VPCS_BIT_BIDIR   3
`define VPCS_HOLD_RESET  7'h00
`define VPCS_WTR_RESET   13'h0BB8

`endif

// [vpcs_pkg.sv]
// Types shared by the VC-12 connection matrix and trail source.
// Assumes vpcs_defs.svh is on the include path.
package vpcs_pkg;
   `include "vpcs_defs.svh"

   // Monitoring flavour of a protected connection
   typedef enum logic [1:0] {
      vpcs_inherent, vpcs_nonintrusive, vpcs_sublayer
   } vpcs_kind_type;

   // External commands, code order is the software encoding
   typedef enum logic [2:0] {
      vpcs_cmd_none, vpcs_cmd_clear, vpcs_cmd_lockout, vpcs_cmd_force_prot,
      vpcs_cmd_force_work, vpcs_cmd_manual_prot, vpcs_cmd_manual_work
   } vpcs_cmd_type;

   // One connection point input
   typedef struct packed {
      logic [7:0] d;
      logic       ck;
      logic       fs;
      logic       ssf;
      logic       tsf;
      logic       tsd;
   } vpcs_cp_type;

   // One connection point output
   typedef struct packed {
      logic [7:0] d;
      logic       ck;
      logic       fs;
      logic       ssf;
   } vpcs_cpo_type;

   // Adapted information stream into the trail source
   typedef struct packed {
      logic [7:0] d;
      logic       ck;
      logic       fs;
   } vpcs_ai_type;

   // Per output point configuration and protection state
   typedef struct packed {
      logic          conn;
      logic          prot_on;
      logic          revert;
      logic          bidir;
      vpcs_kind_type kind;
      logic [1:0]    work_idx;
      logic [1:0]    prot_idx;
      logic [6:0]    holdoff;
      logic [12:0]   wtr;
      vpcs_cmd_type  cmd;
      logic          use_prot;
      logic [6:0]    ho_cnt;
      logic [12:0]   wtr_cnt;
      vpcs_cpo_type  out;
   } vpcs_grp_type;
endpackage

// [vpcs_path_checker.sv]
// Checker for the VC-12 connection matrix and trail source ports.
// Assumes a bind onto vpcs_path_connect_source from the bench.
`timescale 1ns/1ns
`include "vpcs_defs.svh"
module vpcs_path_checker (
   // Clock and reset
   input wire logic                         clk_sys,
   input wire logic                         reset_n,
   // Watched ports
   input wire vpcs_pkg::vpcs_cpo_type [3:0] cp_out,
   input wire logic                         ti_ck,
   input wire logic                         ti_fs,
   input wire vpcs_pkg::vpcs_ai_type        ai_in,
   input wire logic [1:0]                   remote_error_request,
   input wire logic                         remote_defect_request,
   input wire vpcs_pkg::vpcs_ai_type        ci_out,
   input wire logic                         reg_wr
);
   // ****************
   // Stream tracking
   // ****************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic [7:0] pos;
   logic [7:0] acc;
   logic [7:0] cur;
   logic [1:0] bip;
   logic [2:0] up;
   logic       seen;
   logic       cfg;
   logic       pck;
   logic       edg;
   // Byte edge, position and parity of the previous frame
   assign edg = ci_out.ck & ~pck;
   assign cur = ci_out.fs ? 8'h00 : pos + 8'h01;
   assign bip = {^{acc[7], acc[5], acc[3], acc[1]}, ^{acc[6], acc[4], acc[2], acc[0]}};
   // Restart on reset so a second reset begins a fresh frame
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pos  <= 8'h00;
         acc  <= 8'h00;
         up   <= 3'h0;
         seen <= 1'b0;
         cfg  <= 1'b0;
         pck  <= 1'b0;
      end else begin
         pck  <= ci_out.ck;
         cfg  <= cfg | reg_wr;
         up   <= (up == 3'h4) ? up : up + 3'h1;
         seen <= seen | (edg & ci_out.fs);
         if (edg) begin
            pos <= cur;
            acc <= ci_out.fs ? ci_out.d : acc ^ ci_out.d;
         end
      end
   end
   property p_ck_follow;
      $rose(ai_in.ck) |-> ##[2:6] edg;
   endproperty
   a_ck_follow: assert property (p_ck_follow) else $error("byte clock lost");
   property p_data_on_ck;
      $changed({ci_out.d, ci_out.fs}) |-> edg;
   endproperty
   a_data_on_ck: assert property (p_data_on_ck) else $error("byte moved off clock");
   property p_frame_len;
      edg && ci_out.fs && seen |-> pos == 8'h8B;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
   property p_parity;
      edg && ci_out.fs && seen |-> ci_out.d[7:6] == bip;
   endproperty
   a_parity: assert property (p_parity) else $error("status parity wrong");
   property p_rem_err;
      edg && ci_out.fs |-> ci_out.d[5] == (|remote_error_request);
   endproperty
   a_rem_err: assert property (p_rem_err) else $error("remote error bit wrong");
   property p_rem_def;
      edg && ci_out.fs |-> ci_out.d[0] == remote_defect_request;
   endproperty
   a_rem_def: assert property (p_rem_def) else $error("remote defect bit wrong");
   property p_ext;
      edg && seen && cur == `VPCS_POS_EXT |-> ci_out.d[3:1] inside {3'h0, 3'h7};
   endproperty
   a_ext: assert property (p_ext) else $error("extended status code wrong");
   property p_uneq;
      !cfg && up == 3'h4 |-> cp_out[2].ck == $past(ti_ck, 3) && cp_out[2].fs == $past(ti_fs, 3);
   endproperty
   a_uneq: assert property (p_uneq) else $error("unequipped timing wrong");
endmodule

// [vpcs_ai_model.sv]
// Model of the adaptation source that feeds the trail source.
// Assumes the bench raises run after reset and captures the bytes itself.
`timescale 1ns/1ns
`include "vpcs_defs.svh"
module vpcs_ai_model (
   // Control
   input  wire logic                 run,
   input  wire logic                 slow,
   // Stream towards the trail source
   output var vpcs_pkg::vpcs_ai_type ai
);
   // ****************
   // Frame generator
   // ****************
   int p;
   initial begin
      ai = '0;
      // Step 1 ns off the clock edge so no byte edge races the sampling edge
      wait (run);
      #1;
      forever begin
         wait (run);
         for (p = 0; p < `VPCS_FRAME_LEN; p++) begin
            ai.d  = 8'($urandom);
            ai.fs = (p == 0);
            #32 ai.ck = 1'b1;
            #32 ai.ck = 1'b0;
            // Slow mode stretches the low phase, never the frame content
            if (slow) #64;
         end
         // Released line must not look like held data
         if (!run) ai.d = ~ai.d;
      end
   end
endmodule

// [testbench.sv]
// Self-checking bench for the path connection and trail source block.
// Assumes the design, the checker and the stream model compile first.
`timescale 1ns/1ns
`include "vpcs_defs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
   $display("FAIL %s exp %0h got %0h", n, e, a); end end
module testbench;
   // ****************
   // Bench
   // ****************
   localparam int STEP = 20;
   logic                         clk_sys, reset_n, ti_ck, ti_fs, reg_wr, reg_rd;
   logic                         remote_defect_indication, run, slow, pck;
   logic [1:0]                   remote_error_indication;
   logic [7:0]                   reg_addr, pos, trace;
   logic [8:0]                   x;
   logic [31:0]                  reg_wdata, reg_rdata;
   logic [8:0]                   q[$];
   vpcs_pkg::vpcs_cp_type [3:0]  cp_in;
   vpcs_pkg::vpcs_cpo_type [3:0] cp_out;
   vpcs_pkg::vpcs_ai_type        ai_in, ci_out;
   int                           errors, checks, cyc;
   vpcs_ai_model vpcs_ai_model_inst (.run(run), .slow(slow), .ai(ai_in));
   vpcs_path_connect_source #(.STEP_CYC(STEP)) vpcs_path_connect_source_inst (
      .clk_sys(clk_sys), .reset_n(reset_n), .cp_in(cp_in), .cp_out(cp_out),
      .ti_ck(ti_ck), .ti_fs(ti_fs), .ai_in(ai_in), .remote_error_request(remote_error_indication),
      .remote_defect_request(remote_defect_indication), .ci_out(ci_out), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Local timing wanders and a hang is cut short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      ti_fs <= 1'($urandom);
      if (cyc[2:0] == 3'h0) ti_ck <= ~ti_ck;
      if (cyc > 60000) begin
         errors++;
         tally_and_finish();
      end
   end
   // Bytes offered to the trail source, in order
   always @(posedge ai_in.ck) q.push_back({ai_in.fs, ai_in.d});
   // Compare each outgoing byte with what went in
   always @(posedge clk_sys) begin
      pck <= ci_out.ck;
      if (ci_out.ck && !pck && q.size() > 0) begin
         x = q.pop_front();
         pos = ci_out.fs ? 8'h00 : pos + 8'h01;
         `CHK("frame start", x[8], ci_out.fs)
         if (pos == `VPCS_POS_TRACE) `CHK("trace", trace, ci_out.d)
         else if (pos == `VPCS_POS_EXT) `CHK("ext", x[7:4], ci_out.d[7:4])
         else if (pos == 8'h00) `CHK("label", x[4:1], ci_out.d[4:1])
         else `CHK("client", x[7:0], ci_out.d)
         // Remote requests move mid-frame so the next status byte is settled
         if (pos == 8'h46) begin
            remote_error_indication <= 2'($urandom_range(2));
            remote_defect_indication <= 1'($urandom);
         end
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 `CHK("reg", e, reg_rdata)
   endtask
   function automatic logic [8:0] want(input int i);
      return (i > 3) ? 9'h000 : {cp_in[i].d, cp_in[i].ssf};
   endfunction
   // Output g is expected to carry input i, index 4 meaning unequipped
   task automatic sel(input int g, input int i, input int n);
      repeat (n) @(posedge clk_sys);
      #1 `CHK("cp_out", want(i), {cp_out[g].d, cp_out[g].ssf})
   endtask
   initial begin
      void'($urandom(76));
      {reg_wr, reg_rd, run, slow, remote_defect_indication, ti_ck, ti_fs, pck} = '0;
      {remote_error_indication, reg_addr, reg_wdata, cp_in, errors, checks, cyc} = '0;
      reset_n = 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int k = 0; k < 4; k++) cp_in[k] <= {6'($urandom), 2'(k), 5'h00};
      trace = 8'($urandom);
      for (int g = 0; g < 4; g++) sel(g, 4, 8);
      for (int k = 0; k < 4; k++) wr(8'h40 + 8'(4 * k), {4{trace}});
      run <= 1'b1;
      wr(8'h00, 32'h0000_0101);
      wr(8'h10, 32'h0000_0101);
      wr(8'h20, 32'h0000_0001);
      sel(0, 1, 6);
      sel(1, 1, 0);
      sel(2, 0, 0);
      sel(3, 4, 0);
      rd(8'h10, 32'h0000_0101);
      rd(8'hF0, 32'h0000_0000);
      wr(8'h10, 32'h0000_0000);
      sel(1, 4, 6);
      wr(8'h04, 32'h0000_0002);
      wr(8'h08, 32'h0000_0003);
      wr(8'h00, 32'h0000_0907);
      for (int k = 0; k < 12; k++) sel(0, 1, 1);
      slow <= 1'b1;
      @(posedge clk_sys) cp_in[1].ssf <= 1'b1;
      sel(0, 1, 15);
      sel(0, 2, 100);
      @(posedge clk_sys) cp_in[1].ssf <= 1'b0;
      sel(0, 2, 30);
      sel(0, 1, 120);
      wr(8'h0C, 32'h0000_0003);
      sel(0, 2, 10);
      rd(8'h0C, 32'h0000_000B);
      wr(8'h0C, 32'h0000_0006);
      rd(8'h0C, 32'h0000_000B);
      wr(8'h0C, 32'h0000_0002);
      sel(0, 1, 10);
      rd(8'h0C, 32'h0000_0002);
      wr(8'h0C, 32'h0000_0001);
      wr(8'h00, 32'h0000_0903);
      @(posedge clk_sys) cp_in[1].ssf <= 1'b1;
      sel(0, 2, 100);
      @(posedge clk_sys) cp_in[1].ssf <= 1'b0;
      sel(0, 2, 150);
      wr(8'h0C, 32'h0000_0004);
      sel(0, 1, 10);
      wr(8'h0C, 32'h0000_0005);
      sel(0, 2, 10);
      rd(8'h0C, 32'h0000_000D);
      wr(8'h0C, 32'h0000_0001);
      wr(8'h00, 32'h0000_0917);
      sel(0, 1, 150);
      @(posedge clk_sys) cp_in[1].ssf <= 1'b1;
      sel(0, 1, 100);
      @(posedge clk_sys) cp_in[1] <= {cp_in[1].d, 5'b00010};
      sel(0, 2, 100);
      @(posedge clk_sys) cp_in[1].tsf <= 1'b0;
      sel(0, 1, 150);
      @(posedge clk_sys) cp_in[1].tsd <= 1'b1;
      sel(0, 2, 100);
      @(posedge clk_sys) slow <= 1'b0;
      repeat (20000) @(posedge clk_sys);
      tally_and_finish();
   end
endmodule
bind vpcs_path_connect_source vpcs_path_checker vpcs_path_checker_inst (
   .clk_sys(clk_sys), .reset_n(reset_n), .cp_out(cp_out), .ti_ck(ti_ck), .ti_fs(ti_fs),
   .ai_in(ai_in), .remote_error_request(remote_error_request),
   .remote_defect_request(remote_defect_request), .ci_out(ci_out), .reg_wr(reg_wr));
